// file: rtl/pil_top.sv
`timescale 1ns/100ps
`default_nettype none

`include "pil_map.svh"

module pil_top import pil_pkg::*; (
	input  wire logic       CLOCK,
	input  wire logic       RESET,
	input  wire logic [4:0] IO_ADDR,
	input  wire pil_op_t    IO_OP,
	input  wire logic [1:0] IO_BIT,
	input  wire logic       IO_USE_INDEX,
	input  wire logic [3:0] IO_INDEX,
	input  wire logic [3:0] IO_WDATA,
	input  wire logic       IO_S3,
	input  wire logic       IO_S4,
	input  wire logic       MASTER_IRQ_EN,
	input  wire logic       IRQ_EN_BIT0,
	input  wire logic [3:0] NIBBLE_A_IN,
	output var  logic [3:0] NIBBLE_A_OUT,
	output var  logic [3:0] NIBBLE_A_OE_N,
	input  wire logic [3:0] NIBBLE_B_IN,
	output var  logic [3:0] NIBBLE_B_OUT,
	output var  logic [3:0] NIBBLE_B_OE_N,
	input  wire logic [1:0] SHARED_IN,
	output var  logic [1:0] SHARED_OUT,
	output var  logic [1:0] SHARED_OE_N,
	input  wire logic       HOLD_IN,
	output var  logic       HOLD_OUT,
	output var  logic       HOLD_OE_N,
	output var  logic [3:0] RD_DATA,
	output var  logic       RD_VALID,
	output var  logic       TEST_RESULT,
	output var  logic       TEST_VALID,
	output var  logic [3:0] HOLD_MODE_CMD,
	output var  logic [3:0] INTERVAL_TICK_CMD,
	output var  logic [3:0] COUNTER_ONE_CMD,
	output var  logic [3:0] COUNTER_TWO_CMD,
	output var  logic       EXT_IRQ_ONE,
	output var  logic       EXT_IRQ_TWO
);

	////////////////////////////////////////////////////////////////////////
	// Address and operation decode.

	logic       bit_op;      // Set, clear or test instruction.
	logic       index_mode;  // Bit operation addressed by the index register.
	logic       bit_ok;      // The addressed pin exists.
	logic [4:0] eff_addr;    // Port address after index translation.
	logic [1:0] eff_bit;     // Bit number after index translation.
	logic       hit_a;       // Nibble port A addressed.
	logic       hit_b;       // Nibble port B addressed.
	logic       hit_s;       // Shared port addressed.
	logic       hit_k;       // Sense input addressed.
	logic       out_go;      // Whole-word write strobe.
	logic       set_go;      // Bit set strobe.
	logic       clr_go;      // Bit clear strobe.
	logic       in_go;       // Read sample strobe.
	logic       test_go;     // Bit test sample strobe.

	assign bit_op = (IO_OP == PIL_OP_SET) || (IO_OP == PIL_OP_CLR) ||
	                (IO_OP == PIL_OP_TEST);
	assign index_mode = IO_USE_INDEX & bit_op;
	// An index with its top bit set reaches no pin.
	assign bit_ok = ~index_mode | ~IO_INDEX[`PIL_IDX_NONE_BIT];
	// Index bit 2 picks port B, bits 1..0 the pin.
	assign eff_addr = !index_mode ? IO_ADDR :
	                  IO_INDEX[`PIL_IDX_PORT_BIT] ? `PIL_ADDR_NIBBLE_B :
	                  `PIL_ADDR_NIBBLE_A;
	assign eff_bit = index_mode ? IO_INDEX[1:0] : IO_BIT;

	// Full five-bit compare on every port select.
	assign hit_a = bit_ok && (eff_addr == `PIL_ADDR_NIBBLE_A);
	assign hit_b = bit_ok && (eff_addr == `PIL_ADDR_NIBBLE_B);
	assign hit_s = !index_mode && (eff_addr == `PIL_ADDR_SHARED);
	assign hit_k = !index_mode && (eff_addr == `PIL_ADDR_SENSE);

	// Writes land in S4, reads and tests sample in S3.
	assign out_go  = IO_S4 && (IO_OP == PIL_OP_OUT);
	assign set_go  = IO_S4 && (IO_OP == PIL_OP_SET);
	assign clr_go  = IO_S4 && (IO_OP == PIL_OP_CLR);
	assign in_go   = IO_S3 && (IO_OP == PIL_OP_IN);
	assign test_go = IO_S3 && (IO_OP == PIL_OP_TEST);

	////////////////////////////////////////////////////////////////////////
	// Output latches.

	pil_latch_if #(.W(4)) a_if ();  // Nibble port A latches.
	pil_latch_if #(.W(4)) b_if ();  // Nibble port B latches.
	pil_latch_if #(.W(4)) s_if ();  // Shared port latches, bits 0..3.

	// Strobes routed only to the addressed latch group.
	assign a_if.load  = out_go & hit_a;
	assign a_if.set   = set_go & hit_a;
	assign a_if.clr   = clr_go & hit_a;
	assign a_if.wdata = IO_WDATA;
	assign a_if.bsel  = eff_bit;
	assign b_if.load  = out_go & hit_b;
	assign b_if.set   = set_go & hit_b;
	assign b_if.clr   = clr_go & hit_b;
	assign b_if.wdata = IO_WDATA;
	assign b_if.bsel  = eff_bit;
	assign s_if.load  = out_go & hit_s;
	assign s_if.set   = set_go & hit_s;
	assign s_if.clr   = clr_go & hit_s;
	assign s_if.wdata = IO_WDATA;
	assign s_if.bsel  = eff_bit;

	// Both nibble ports preset to ones at reset.
	pil_latch #(.W(4), .RST(`PIL_LATCH_RESET)) u_latch_a (
		.clk (CLOCK),
		.rst (RESET),
		.lif (a_if)
	);
	pil_latch #(.W(4), .RST(`PIL_LATCH_RESET)) u_latch_b (
		.clk (CLOCK),
		.rst (RESET),
		.lif (b_if)
	);
	// Shared port keeps four latch bits; two drive its pins, bit 2 the hold pin.
	pil_latch #(.W(4), .RST(`PIL_LATCH_RESET)) u_latch_s (
		.clk (CLOCK),
		.rst (RESET),
		.lif (s_if)
	);

	////////////////////////////////////////////////////////////////////////
	// Pin drive: the data level is always low and the enable follows the
	// latch, so a one releases the pin to the outside pull-up.

	assign NIBBLE_A_OUT  = 4'h0;
	assign NIBBLE_A_OE_N = a_if.q;
	assign NIBBLE_B_OUT  = 4'h0;
	assign NIBBLE_B_OE_N = b_if.q;
	assign SHARED_OUT    = 2'h0;
	assign SHARED_OE_N   = s_if.q[1:0];
	// Bit 2 of the shared latch pulls the hold pin internally.
	assign HOLD_OUT      = 1'b0;
	assign HOLD_OE_N     = s_if.q[2];

	////////////////////////////////////////////////////////////////////////
	// Read and test paths take the pins directly, with no input latch.

	logic [3:0] rd_mux;    // Nibble returned by a read.
	logic [3:0] sense_nib; // Sense port nibble, bit 0 inverted pin.
	logic [3:0] shared_nib; // Shared port pins, bit 2 the hold pin.
	logic       test_mux;  // Bit returned by a test.

	// Upper sense bits are undefined; they read as zero here.
	assign sense_nib = {3'h0, ~HOLD_IN};
	assign shared_nib = {1'b0, HOLD_IN, SHARED_IN};

	// The command window 10..1f always answers with the undefined value.
	assign rd_mux =
		IO_ADDR[`PIL_ADDR_CMD_BIT] ? `PIL_UNDEF_READ :
		(IO_ADDR == `PIL_ADDR_NIBBLE_A) ? NIBBLE_A_IN :
		(IO_ADDR == `PIL_ADDR_NIBBLE_B) ? NIBBLE_B_IN :
		(IO_ADDR == `PIL_ADDR_SHARED)   ? shared_nib :
		(IO_ADDR == `PIL_ADDR_SENSE)    ? sense_nib :
		`PIL_UNDEF_READ;

	assign test_mux = hit_a ? NIBBLE_A_IN[eff_bit] :
	                  hit_b ? NIBBLE_B_IN[eff_bit] :
	                  hit_k ? sense_nib[eff_bit] : 1'b0;

	// Read data and test result are captured at S3 and held.
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			RD_DATA     <= 4'h0;
			RD_VALID    <= 1'b0;
			TEST_RESULT <= 1'b0;
			TEST_VALID  <= 1'b0;
		end else begin
			RD_VALID   <= in_go;
			TEST_VALID <= test_go;
			if (in_go) begin
				RD_DATA <= rd_mux;
			end
			if (test_go) begin
				TEST_RESULT <= test_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write-only command ports.

	logic wr_hold;  // Hold mode command write.
	logic wr_itv;   // Interval tick command write.
	logic wr_c1;    // Counter one command write.
	logic wr_c2;    // Counter two command write.

	assign wr_hold = out_go && (IO_ADDR == `PIL_ADDR_HOLD_MODE);
	assign wr_itv  = out_go && (IO_ADDR == `PIL_ADDR_INTERVAL);
	assign wr_c1   = out_go && (IO_ADDR == `PIL_ADDR_COUNTER1);
	assign wr_c2   = out_go && (IO_ADDR == `PIL_ADDR_COUNTER2);

	// Command registers clear at reset and load at S4.
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			HOLD_MODE_CMD     <= `PIL_CMD_RESET;
			INTERVAL_TICK_CMD <= `PIL_CMD_RESET;
			COUNTER_ONE_CMD   <= `PIL_CMD_RESET;
			COUNTER_TWO_CMD   <= `PIL_CMD_RESET;
		end else begin
			if (wr_hold) begin
				HOLD_MODE_CMD <= IO_WDATA;
			end
			if (wr_itv) begin
				INTERVAL_TICK_CMD <= IO_WDATA;
			end
			if (wr_c1) begin
				COUNTER_ONE_CMD <= IO_WDATA;
			end
			if (wr_c2) begin
				COUNTER_TWO_CMD <= IO_WDATA;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External interrupt edge detection.

	logic hold_prev_reg;  // Hold pin level one cycle ago.
	logic ext_irq_two_prev_reg;  // Shared pin 0 level one cycle ago.
	logic fall_one;       // Falling edge on the hold pin.
	logic fall_two;       // Falling edge on shared pin 0.

	assign fall_one = hold_prev_reg & ~HOLD_IN;
	assign fall_two = ext_irq_two_prev_reg & ~SHARED_IN[0];

	// The hold pin edge raises interrupt one whatever the pin is used for;
	// interrupt two also needs enable bit 0.
	always_ff @(posedge CLOCK or posedge RESET) begin
		if (RESET) begin
			hold_prev_reg <= 1'b1;
			ext_irq_two_prev_reg <= 1'b1;
			EXT_IRQ_ONE   <= 1'b0;
			EXT_IRQ_TWO   <= 1'b0;
		end else begin
			hold_prev_reg <= HOLD_IN;
			ext_irq_two_prev_reg <= SHARED_IN[0];
			EXT_IRQ_ONE   <= fall_one & MASTER_IRQ_EN;
			EXT_IRQ_TWO   <= fall_two & MASTER_IRQ_EN &
			                 IRQ_EN_BIT0;
		end
	end

endmodule // pil_top

`default_nettype wire

// file: include/pil_map.svh
`ifndef PIL_MAP_SVH
`define PIL_MAP_SVH

// Port addresses as carried by the I/O instruction.
`define PIL_ADDR_W          5
`define PIL_ADDR_NIBBLE_A   5'h04
`define PIL_ADDR_NIBBLE_B   5'h05
`define PIL_ADDR_SHARED     5'h08
`define PIL_ADDR_SENSE      5'h0e
`define PIL_ADDR_HOLD_MODE  5'h10
`define PIL_ADDR_INTERVAL   5'h19
`define PIL_ADDR_COUNTER1   5'h1c
`define PIL_ADDR_COUNTER2   5'h1d

// Address bit that marks the command window 10..1f.
`define PIL_ADDR_CMD_BIT    4

// Index register fields.
`define PIL_IDX_NONE_BIT    3
`define PIL_IDX_PORT_BIT    2

// Data widths and reset values.
`define PIL_NIB_W           4
`define PIL_LATCH_RESET     4'hf
`define PIL_CMD_RESET       4'h0
`define PIL_UNDEF_READ      4'h0

`endif

// file: include/pil_pkg.sv
package pil_pkg;

	// Operation presented by the core for the current I/O instruction.
	typedef enum logic [2:0] {
		PIL_OP_NONE,
		PIL_OP_IN,
		PIL_OP_OUT,
		PIL_OP_SET,
		PIL_OP_CLR,
		PIL_OP_TEST
	} pil_op_t;

endpackage

// file: include/pil_latch_if.sv
`timescale 1ns/100ps
`default_nettype none

// Carries the update strobes into one latch group and its state back out.
interface pil_latch_if #(parameter int W = 4);
	logic         load;   // Whole-word write.
	logic [W-1:0] wdata;  // Data for a whole-word write.
	logic         set;    // Set the addressed bit.
	logic         clr;    // Clear the addressed bit.
	logic [1:0]   bsel;   // Addressed bit.
	logic [W-1:0] q;      // Present latch contents.

	modport ctrl  (output load, wdata, set, clr, bsel, input q);
	modport latch (input load, wdata, set, clr, bsel, output q);
endinterface

`default_nettype wire

// file: rtl/pil_latch.sv
`timescale 1ns/100ps
`default_nettype none

// One group of output latch bits with word write and bit set or clear.
module pil_latch #(
	parameter int         W     = 4,
	parameter logic [W-1:0] RST = '1
) (
	input  wire logic       clk,
	input  wire logic       rst,
	pil_latch_if.latch      lif
);
	logic [W-1:0] latch_reg;   // Stored output levels.
	logic [W-1:0] latch_next;  // Value to store at the next edge.
	logic [W-1:0] onehot;      // Mask of the addressed bit.

	// A bit index beyond the group width selects nothing.
	assign onehot = W'(1) << lif.bsel;

	// Word write wins; otherwise a bit is set or cleared.
	assign latch_next = lif.load ? lif.wdata :
	                    lif.set  ? (latch_reg | onehot) :
	                    lif.clr  ? (latch_reg & ~onehot) : latch_reg;

	// Latches preset to all ones so every pin starts released.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_reg <= RST;
		end else begin
			latch_reg <= latch_next;
		end
	end

	assign lif.q = latch_reg;
endmodule // pil_latch

`default_nettype wire

// file: bench/pil_pins_model.sv
`timescale 1ns/100ps
`default_nettype none

// Outside circuits on the open-drain pins, with pull-ups on every wire.
// Bits 3..0 nibble A, 7..4 nibble B, 9..8 shared port, 10 hold pin.
module pil_pins_model (
	input  wire logic [10:0] oe_n,   // Device enables, low drives the wire.
	input  wire logic [10:0] drv,    // Device data levels while enabled.
	input  wire logic [10:0] ext_lo, // Outside pull-downs.
	output var  logic [10:0] level   // Wire levels fed back as inputs.
);
	// A driven wire shows the device data; a released one shows the
	// pull-up unless an outside circuit pulls it down.
	assign level = (oe_n | drv) & ~ext_lo;
endmodule // pil_pins_model

`default_nettype wire

// file: bench/pil_top_props.sv
`timescale 1ns/100ps
`default_nettype none

// Watches the port block from its own pins.
module pil_top_props import pil_pkg::*; (
	input wire logic       CLOCK,
	input wire logic       RESET,
	input wire logic [4:0] IO_ADDR,
	input wire pil_op_t    IO_OP,
	input wire logic       IO_USE_INDEX,
	input wire logic [3:0] IO_INDEX,
	input wire logic [3:0] IO_WDATA,
	input wire logic       IO_S3,
	input wire logic       IO_S4,
	input wire logic       MASTER_IRQ_EN,
	input wire logic       IRQ_EN_BIT0,
	input wire logic [1:0] SHARED_IN,
	input wire logic       HOLD_IN,
	input wire logic [3:0] NIBBLE_A_OE_N,
	input wire logic [3:0] NIBBLE_B_OE_N,
	input wire logic [3:0] RD_DATA,
	input wire logic       RD_VALID,
	input wire logic [3:0] INTERVAL_TICK_CMD,
	input wire logic       EXT_IRQ_ONE,
	input wire logic       EXT_IRQ_TWO
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	// Write and read strokes to one address.
	sequence s_out(a); IO_OP == PIL_OP_OUT && IO_S4 && IO_ADDR == a; endsequence
	sequence s_in(a); IO_OP == PIL_OP_IN && IO_S3 && IO_ADDR == a; endsequence
	// Interrupt one stands for exactly one cycle.
	sequence s_one_pulse; EXT_IRQ_ONE ##1 !EXT_IRQ_ONE; endsequence

	AST_RST_OPEN: assert property (
		$fell(RESET) |-> NIBBLE_A_OE_N == 4'hf && INTERVAL_TICK_CMD == 4'h0)
		else $error("latch or command not preset after reset");
	AST_OUT_A: assert property (
		s_out(5'h04) |=> NIBBLE_A_OE_N == $past(IO_WDATA))
		else $error("nibble A latch missed its write");
	AST_OUT_B: assert property (
		s_out(5'h05) |=> NIBBLE_B_OE_N == $past(IO_WDATA))
		else $error("nibble B latch missed its write");
	AST_IDX_CLR: assert property (
		IO_OP == PIL_OP_CLR && IO_S4 && IO_USE_INDEX && IO_INDEX[3:2] == 2'b00
		|=> !NIBBLE_A_OE_N[$past(IO_INDEX[1:0])])
		else $error("indexed clear missed nibble A bit");
	AST_IDX_NONE: assert property (
		(IO_OP == PIL_OP_SET || IO_OP == PIL_OP_CLR) && IO_S4 && IO_USE_INDEX
		&& IO_INDEX[3] |=> $stable(NIBBLE_A_OE_N) && $stable(NIBBLE_B_OE_N))
		else $error("index without pin changed a latch");
	AST_SENSE: assert property (
		s_in(5'h0e) |=> RD_VALID && RD_DATA[0] == !$past(HOLD_IN))
		else $error("sense bit not inverted pin level");
	AST_UNDEF: assert property (
		IO_OP == PIL_OP_IN && IO_S3 && IO_ADDR[4] |=> RD_DATA == 4'h0)
		else $error("command window read not zero");
	AST_IRQ_ONE: assert property (
		$fell(HOLD_IN) && MASTER_IRQ_EN |=> s_one_pulse)
		else $error("hold edge gave no single pulse");
	AST_IRQ_TWO: assert property (
		$fell(SHARED_IN[0]) && MASTER_IRQ_EN && IRQ_EN_BIT0 |=> EXT_IRQ_TWO)
		else $error("second interrupt edge missed");
	AST_IRQ_TWO_OFF: assert property (
		!IRQ_EN_BIT0 |=> !EXT_IRQ_TWO)
		else $error("second interrupt passed while disabled");
	AST_CMD19: assert property (
		s_out(5'h19) |=> INTERVAL_TICK_CMD == $past(IO_WDATA))
		else $error("interval command missed its write");
endmodule // pil_top_props

bind pil_top pil_top_props i_props (.*);

`default_nettype wire

// file: bench/port_io_latches_tb.sv
`timescale 1ns/100ps
`default_nettype none

module port_io_latches_tb;
	import pil_pkg::*;
	logic        clock = 1'b0, reset = 1'b1, s3 = 1'b0, s4 = 1'b0; // Core.
	logic        use_idx = 1'b0, m_en = 1'b0, en0 = 1'b0;        // Enables.
	logic [4:0]  addr = 5'h00;                                    // Port.
	pil_op_t     op = PIL_OP_NONE;                                // Operation.
	logic [3:0]  idx = 4'h0, wdata = 4'h0, a_oe, b_oe, rd, hmc, itc, c1c, c2c;
	logic [3:0]  a_out, b_out;                                    // Pin data.
	logic [1:0]  sh_oe, sh_out, bnum = 2'h0;                      // Shared.
	logic        h_oe, h_out, rd_v, t_res, t_v, irq1, irq2;       // Flags.
	logic [10:0] ext_lo = 11'h000, lvl;                           // Pins.
	int          err_total = 0, n_compared = 0, cyc = 0;          // Counts.

	pil_top i_dut (.CLOCK(clock), .RESET(reset), .IO_ADDR(addr), .IO_OP(op),
		.IO_BIT(bnum), .IO_USE_INDEX(use_idx), .IO_INDEX(idx), .IO_WDATA(wdata),
		.IO_S3(s3), .IO_S4(s4), .MASTER_IRQ_EN(m_en), .IRQ_EN_BIT0(en0),
		.NIBBLE_A_IN(lvl[3:0]), .NIBBLE_A_OUT(a_out), .NIBBLE_A_OE_N(a_oe),
		.NIBBLE_B_IN(lvl[7:4]), .NIBBLE_B_OUT(b_out), .NIBBLE_B_OE_N(b_oe),
		.SHARED_IN(lvl[9:8]), .SHARED_OUT(sh_out), .SHARED_OE_N(sh_oe),
		.HOLD_IN(lvl[10]), .HOLD_OUT(h_out), .HOLD_OE_N(h_oe), .RD_DATA(rd),
		.RD_VALID(rd_v), .TEST_RESULT(t_res), .TEST_VALID(t_v),
		.HOLD_MODE_CMD(hmc), .INTERVAL_TICK_CMD(itc), .COUNTER_ONE_CMD(c1c),
		.COUNTER_TWO_CMD(c2c), .EXT_IRQ_ONE(irq1), .EXT_IRQ_TWO(irq2));
	pil_pins_model i_pins (.oe_n({h_oe, sh_oe, b_oe, a_oe}),
		.drv({h_out, sh_out, b_out, a_out}), .ext_lo(ext_lo), .level(lvl));

	////////////////////////////////////////
	// Prints the verdict and stops.
	task automatic complete_run();
		if (err_total == 0 && n_compared > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Counts a comparison and reports a difference.
	task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// One I/O instruction; the answer is settled on return.
	task automatic io(input pil_op_t o, input logic [4:0] a,
		input logic ui, input logic [3:0] ix, input logic [3:0] d);
		@(posedge clock);
		#1;
		op = o;
		addr = a;
		use_idx = ui;
		idx = ix;
		wdata = d;
		s3 = (o == PIL_OP_IN || o == PIL_OP_TEST);
		s4 = !s3;
		@(posedge clock);
		#1;
		s3 = 1'b0;
		s4 = 1'b0;
		op = PIL_OP_NONE;
	endtask
	// Changes the outside pull-downs just after an edge.
	task automatic pins(input logic [10:0] v);
		@(posedge clock);
		#1;
		ext_lo = v;
	endtask

	////////////////////////////////////////
	// Preset state after any reset.
	task automatic t_reset_vals();
		chk(a_oe, 4'hf);
		chk(b_oe, 4'hf);
		chk({1'b0, h_oe, sh_oe}, 4'h7);
		chk(itc, 4'h0);
		chk(a_out | b_out | {1'b0, h_out, sh_out}, 4'h0);
	endtask
	// Word writes and reads of the present pin level.
	task automatic t_nibble();
		io(PIL_OP_OUT, 5'h04, 1'b0, 4'h0, 4'h5);
		chk(a_oe, 4'h5);
		io(PIL_OP_IN, 5'h04, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'h5);
		chk({3'h0, rd_v}, 4'h1);
		io(PIL_OP_OUT, 5'h04, 1'b0, 4'h0, 4'hf);
		pins(11'h090);
		io(PIL_OP_IN, 5'h05, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'h6);
		pins(11'h000);
		io(PIL_OP_IN, 5'h05, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'hf);
	endtask
	// Clear and set every index value, in range or not.
	task automatic t_index();
		logic [7:0] e;
		for (int i = 0; i < 16; i++) begin
			e = (i < 8) ? ~(8'h01 << i) : 8'hff;
			io(PIL_OP_CLR, 5'h00, 1'b1, i[3:0], 4'h0);
			chk(a_oe, e[3:0]);
			chk(b_oe, e[7:4]);
			io(PIL_OP_SET, 5'h00, 1'b1, i[3:0], 4'h0);
			chk(b_oe, 4'hf);
		end
		io(PIL_OP_TEST, 5'h00, 1'b1, 4'h9, 4'h0);
		chk({2'h0, t_v, t_res}, 4'h2);
		io(PIL_OP_TEST, 5'h00, 1'b1, 4'h5, 4'h0);
		chk({2'h0, t_v, t_res}, 4'h3);
	endtask
	// Bit operations addressed by port number and bit number.
	task automatic t_bitop();
		bnum = 2'h2;
		io(PIL_OP_CLR, 5'h08, 1'b0, 4'h0, 4'h0);
		chk({1'b0, h_oe, sh_oe}, 4'h3);
		io(PIL_OP_SET, 5'h08, 1'b0, 4'h0, 4'h0);
		chk({1'b0, h_oe, sh_oe}, 4'h7);
		bnum = 2'h3;
		io(PIL_OP_TEST, 5'h05, 1'b0, 4'h0, 4'h0);
		chk({2'h0, t_v, t_res}, 4'h3);
		pins(11'h080);
		io(PIL_OP_TEST, 5'h05, 1'b0, 4'h0, 4'h0);
		chk({2'h0, t_v, t_res}, 4'h2);
		chk({3'h0, rd_v}, 4'h0);
		pins(11'h000);
		bnum = 2'h0;
		// A test of the shared port answers zero.
		io(PIL_OP_TEST, 5'h08, 1'b0, 4'h0, 4'h0);
		chk({2'h0, t_v, t_res}, 4'h2);
		// A clear aimed at the sense port reaches no latch.
		io(PIL_OP_CLR, 5'h0e, 1'b0, 4'h0, 4'h0);
		chk(a_oe & b_oe, 4'hf);
		chk({1'b0, h_oe, sh_oe}, 4'h7);
	endtask
	// Shared port latches, the hidden bit driving the hold pin.
	task automatic t_shared();
		// Interrupt acceptance stays off while the pins serve as plain I/O.
		io(PIL_OP_OUT, 5'h08, 1'b0, 4'h0, 4'hb);
		chk({1'b0, h_oe, sh_oe}, 4'h3);
		io(PIL_OP_IN, 5'h08, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'h3);
		io(PIL_OP_OUT, 5'h08, 1'b0, 4'h0, 4'hf);
		io(PIL_OP_IN, 5'h0e, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'h0);
		pins(11'h400);
		io(PIL_OP_IN, 5'h0e, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'h1);
		pins(11'h000);
	endtask
	// One falling edge under given enables.
	task automatic t_irq(input logic [10:0] lo, input logic me,
		input logic e0, input logic [3:0] exp);
		@(posedge clock);
		#1;
		m_en = me;
		en0 = e0;
		pins(lo);
		@(posedge clock);
		#1;
		chk({2'h0, irq2, irq1}, exp);
		pins(11'h000);
	endtask
	// Command ports, reads of the command window, then a second reset.
	// Reserved addresses are never issued.
	task automatic t_cmd();
		io(PIL_OP_OUT, 5'h10, 1'b0, 4'h0, 4'h3);
		io(PIL_OP_OUT, 5'h19, 1'b0, 4'h0, 4'h6);
		io(PIL_OP_OUT, 5'h1c, 1'b0, 4'h0, 4'h9);
		io(PIL_OP_OUT, 5'h1d, 1'b0, 4'h0, 4'hc);
		chk(hmc, 4'h3);
		chk(itc, 4'h6);
		chk(c1c, 4'h9);
		chk(c2c, 4'hc);
		io(PIL_OP_IN, 5'h19, 1'b0, 4'h0, 4'h0);
		chk(rd, 4'h0);
		io(PIL_OP_OUT, 5'h05, 1'b0, 4'h0, 4'h0);
		@(posedge clock);
		#1;
		reset = 1'b1;
		@(posedge clock);
		#1;
		reset = 1'b0;
		t_reset_vals();
	endtask

	////////////////////////////////////////
	// Clock, watchdog and main sequence.
	initial forever #10 clock = ~clock;
	always @(posedge clock) begin
		cyc++;
		if (cyc == 2000) begin
			err_total++;
			complete_run();
		end
	end
	initial begin
		repeat (3) @(posedge clock);
		#1;
		reset = 1'b0;
		t_reset_vals();
		t_nibble();
		t_index();
		t_shared();
		t_bitop();
		// The hold pin as plain I/O still interrupts; the core would answer
		// with a handler that only returns.
		t_irq(11'h400, 1'b1, 1'b0, 4'h1);
		t_irq(11'h400, 1'b0, 1'b1, 4'h0);
		t_irq(11'h100, 1'b1, 1'b0, 4'h0);
		t_irq(11'h100, 1'b1, 1'b1, 4'h2);
		t_cmd();
		complete_run();
	end
endmodule // port_io_latches_tb

`default_nettype wire
